// ### hw/timer8_pkg.sv
// package: shared constants, modes and carriers of the 8-bit waveform timer
package timer8_pkg;
    localparam int COUNT_W = 8;                  // counter width
    localparam logic [7:0] BOTTOM = 8'h00;       // lowest count
    localparam logic [7:0] MAX = 8'hff;          // highest count
    localparam logic [7:0] COUNT_RESET = 8'h00;  // counter after reset
    localparam logic [7:0] COMPARE_RESET = 8'h00; // compare value after reset
    localparam logic COMP_OUT_RESET = 1'b0;      // compare output after reset
    localparam logic [1:0] MODE_NORMAL = 2'h0;   // free-running
    localparam logic [1:0] MODE_PHASE = 2'h1;    // dual-slope pwm
    localparam logic [1:0] MODE_CTC = 2'h2;      // clear on compare
    localparam logic [1:0] MODE_FAST = 2'h3;     // single-slope pwm
    localparam logic [1:0] ACT_NONE = 2'h0;      // disconnected, no change
    localparam logic [1:0] ACT_TOGGLE = 2'h1;    // toggle on match
    localparam logic [1:0] ACT_CLEAR = 2'h2;     // clear / non-inverting
    localparam logic [1:0] ACT_SET = 2'h3;       // set / inverting

    // software writes into the timer
    typedef struct packed {
        logic count_we;          // count write strobe
        logic [7:0] count_wdata; // count write data
        logic compare_we;        // compare write strobe
        logic [7:0] compare_wdata; // compare write data
        logic force_match;       // forced compare strobe, non-pwm modes
        logic ovf_clear;         // write-one-to-clear of overflow flag
        logic cmp_clear;         // write-one-to-clear of match flag
    } sw_write_t;
endpackage

// ### hw/timer8_wavegen.sv
// module: compare output level generator for every mode and action except toggle in dual slope, which holds the level
`timescale 1ns/1ns
module timer8_wavegen
(
    input wire logic core_clk, // system clock
    input wire logic srst, // synchronous reset, active high
    input wire logic tick, // prescaled timer enable
    input wire logic [1:0] waveform_mode_select, // counting mode
    input wire logic [1:0] compare_output_action, // output action
    input wire logic match, // unblocked compare match this tick
    input wire logic force_match, // forced match strobe
    input wire logic at_bottom, // counter wraps to bottom this tick
    input wire logic counting_up, // direction in dual-slope mode
    input wire logic at_max_turn, // counter at max turnaround this tick
    input wire logic compare_is_max, // active compare equals max
    input wire logic missed_up, // up match missed, counter started above
    output logic compare_output // internal output level
);
    wire logic pwm_mode = waveform_mode_select == timer8_pkg::MODE_FAST
        || waveform_mode_select == timer8_pkg::MODE_PHASE; // pwm modes
    wire logic inv = compare_output_action == timer8_pkg::ACT_SET; // inverting
    wire logic hit = match || (force_match && !pwm_mode); // effective match
    // level after an up-count match in dual slope: low unless inverting
    wire logic up_level = inv;
    logic next_out; // next output level

    // output selection by mode and action
    always_comb
    begin
        next_out = compare_output;
        case (waveform_mode_select)
            timer8_pkg::MODE_NORMAL, timer8_pkg::MODE_CTC:
            begin
                if (hit)
                begin
                    case (compare_output_action)
                        timer8_pkg::ACT_TOGGLE: next_out = !compare_output;
                        timer8_pkg::ACT_CLEAR: next_out = 1'b0;
                        timer8_pkg::ACT_SET: next_out = 1'b1;
                        default: next_out = compare_output;
                    endcase
                end
            end
            timer8_pkg::MODE_FAST:
            begin
                case (compare_output_action)
                    timer8_pkg::ACT_TOGGLE:
                        if (match)
                            next_out = !compare_output;
                    timer8_pkg::ACT_CLEAR, timer8_pkg::ACT_SET:
                    begin
                        // match wins over bottom so compare at max holds the match level
                        if (match)
                            next_out = inv;
                        else if (at_bottom)
                            next_out = !inv;
                    end
                    default: next_out = compare_output;
                endcase
            end
            timer8_pkg::MODE_PHASE:
            begin
                if (compare_output_action[1])
                begin
                    if (at_max_turn && compare_is_max)
                        next_out = !up_level;
                    else if (at_max_turn && missed_up)
                        next_out = up_level;
                    else if (match)
                        next_out = counting_up ? up_level : !up_level;
                end
            end
            default: next_out = compare_output;
        endcase
    end

    // output register advances on timer ticks and on forced matches outside pwm modes
    always_ff @(posedge core_clk)
    begin
        if (srst)
            compare_output <= timer8_pkg::COMP_OUT_RESET;
        else if (tick || (force_match && !pwm_mode))
            compare_output <= next_out;
    end

    no_action_a: assert property (@(posedge core_clk) disable iff (srst)
        (compare_output_action == timer8_pkg::ACT_NONE && !force_match)
        |=> $stable(compare_output)) else $error("output moved with no action");
    fast_set_a: assert property (@(posedge core_clk) disable iff (srst)
        (tick && waveform_mode_select == timer8_pkg::MODE_FAST
        && compare_output_action == timer8_pkg::ACT_CLEAR && at_bottom && !match)
        |=> compare_output) else $error("fast pwm not set at bottom");
endmodule

// ### hw/timer8_waveform_modes.sv
// module: 8-bit timer counter, flags and compare output pin logic
`timescale 1ns/1ns
module timer8_waveform_modes
#(
    parameter int WIDTH = timer8_pkg::COUNT_W // counter width
)
(
    input wire logic core_clk, // system clock, 10 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic timer_tick, // prescaled timer clock enable
    input wire logic [1:0] waveform_mode_select, // counting mode
    input wire logic [1:0] compare_output_action, // output action
    input wire timer8_pkg::sw_write_t sw_write, // software write strobes
    input wire logic output_pin_direction, // pin direction, 1 = output
    input wire logic port_data, // general port output level
    output logic [7:0] count_value, // current count
    output logic [7:0] compare_value, // active compare value
    output logic [7:0] compare_buffer, // software-visible compare buffer
    output logic overflow_flag, // sticky overflow flag
    output logic compare_match_flag, // sticky compare match flag
    output logic pin_out, // pin output level
    output logic pin_oe // pin output enable, high while driving
);
    logic counting_up; // dual-slope direction
    logic block_match; // match blocked after a count write
    logic match_seen_up; // an up-count match happened this slope
    logic compare_output; // internal output register
    logic [7:0] next_count; // next count
    logic next_up; // next direction

    // mode decode; the output action never enters these terms
    wire logic pwm_mode = waveform_mode_select == timer8_pkg::MODE_FAST
        || waveform_mode_select == timer8_pkg::MODE_PHASE;
    wire logic raw_match = count_value == compare_value;
    wire logic match = raw_match && !block_match;
    wire logic is_max = count_value == timer8_pkg::MAX;
    wire logic is_bottom = count_value == timer8_pkg::BOTTOM;
    wire logic phase = waveform_mode_select == timer8_pkg::MODE_PHASE;
    wire logic at_max_turn = phase && is_max && counting_up;
    wire logic fast_wrap = waveform_mode_select == timer8_pkg::MODE_FAST && is_max;
    // buffered compare loads at max for fast, at turnaround top for dual
    wire logic load_point = (waveform_mode_select == timer8_pkg::MODE_FAST && is_max)
        || at_max_turn;

    // next count by mode
    always_comb
    begin
        next_count = count_value;
        next_up = counting_up;
        case (waveform_mode_select)
            timer8_pkg::MODE_NORMAL:
                next_count = count_value + 8'h01;
            timer8_pkg::MODE_CTC:
                // wraps naturally past ff when compare was written low
                // a match blocked by a count write does not clear either
                next_count = match ? timer8_pkg::BOTTOM : count_value + 8'h01;
            timer8_pkg::MODE_FAST:
                next_count = is_max ? timer8_pkg::BOTTOM : count_value + 8'h01;
            timer8_pkg::MODE_PHASE:
            begin
                // max stands for one tick only; the next tick already counts down
                if (counting_up && is_max)
                begin
                    next_up = 1'b0;
                    next_count = count_value - 8'h01;
                end
                else if (!counting_up && is_bottom)
                begin
                    next_up = 1'b1;
                    next_count = count_value + 8'h01;
                end
                else if (counting_up)
                    next_count = count_value + 8'h01;
                else
                    next_count = count_value - 8'h01;
            end
            default: next_count = count_value;
        endcase
    end

    // counter register; software write has priority, ticks gate counting
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            count_value <= timer8_pkg::COUNT_RESET;
            counting_up <= 1'b1;
        end
        else if (sw_write.count_we)
            count_value <= sw_write.count_wdata;
        else if (timer_tick)
        begin
            count_value <= next_count;
            counting_up <= next_up;
        end
    end

    // blocking window: held from a count write until one tick has passed
    always_ff @(posedge core_clk)
    begin
        if (srst)
            block_match <= 1'b0;
        else if (sw_write.count_we)
            block_match <= 1'b1;
        else if (timer_tick)
            block_match <= 1'b0;
    end

    // compare buffer and active compare value
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            compare_buffer <= timer8_pkg::COMPARE_RESET;
            compare_value <= timer8_pkg::COMPARE_RESET;
        end
        else
        begin
            if (sw_write.compare_we)
                compare_buffer <= sw_write.compare_wdata;
            if (!pwm_mode && sw_write.compare_we)
                compare_value <= sw_write.compare_wdata;
            else if (pwm_mode && timer_tick && load_point)
                compare_value <= compare_buffer;
            else if (!pwm_mode)
                compare_value <= compare_buffer;
        end
    end

    // remembers whether the up slope saw its match, for the symmetry fix
    always_ff @(posedge core_clk)
    begin
        if (srst)
            match_seen_up <= 1'b0;
        else if (timer_tick && phase)
        begin
            if (is_bottom && !counting_up)
                match_seen_up <= 1'b0;
            else if (counting_up && match)
                match_seen_up <= 1'b1;
        end
    end

    // overflow event per mode; normal and ctc flag the wrap to zero
    wire logic ovf_event = timer_tick && (
        ((waveform_mode_select == timer8_pkg::MODE_NORMAL
        || waveform_mode_select == timer8_pkg::MODE_CTC)
        && is_max && next_count == timer8_pkg::BOTTOM)
        || (waveform_mode_select == timer8_pkg::MODE_FAST
        && next_count == timer8_pkg::MAX)
        || (phase && !counting_up && next_count == timer8_pkg::BOTTOM));
    wire logic cmp_event = timer_tick && match;

    // sticky flags; a set in the clear cycle wins
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            overflow_flag <= 1'b0;
            compare_match_flag <= 1'b0;
        end
        else
        begin
            if (ovf_event)
                overflow_flag <= 1'b1;
            else if (sw_write.ovf_clear)
                overflow_flag <= 1'b0;
            if (cmp_event)
                compare_match_flag <= 1'b1;
            else if (sw_write.cmp_clear)
                compare_match_flag <= 1'b0;
        end
    end

    // output level generator
    timer8_wavegen u_wavegen
    (
        .core_clk(core_clk),
        .srst(srst),
        .tick(timer_tick),
        .waveform_mode_select(waveform_mode_select),
        .compare_output_action(compare_output_action),
        .match(match),
        .force_match(sw_write.force_match),
        .at_bottom(fast_wrap),
        .counting_up(counting_up),
        .at_max_turn(at_max_turn),
        .compare_is_max(compare_value == timer8_pkg::MAX),
        .missed_up(!match_seen_up && !match && compare_value != timer8_pkg::MAX),
        .compare_output(compare_output)
    );

    // pin override: action nonzero selects the compare level, direction gates drive
    wire logic override = compare_output_action != timer8_pkg::ACT_NONE;
    assign pin_out = override ? compare_output : port_data;
    assign pin_oe = output_pin_direction;

    // checks
    wrap_normal_a: assert property (@(posedge core_clk) disable iff (srst)
        (timer_tick && !sw_write.count_we && waveform_mode_select == timer8_pkg::MODE_NORMAL
        && count_value == 8'hff) |=> count_value == 8'h00 && overflow_flag)
        else $error("normal wrap wrong");
    ctc_clear_a: assert property (@(posedge core_clk) disable iff (srst)
        (timer_tick && !sw_write.count_we && waveform_mode_select == timer8_pkg::MODE_CTC
        && match) |=> count_value == 8'h00) else $error("ctc no clear");
    fast_wrap_a: assert property (@(posedge core_clk) disable iff (srst)
        (timer_tick && !sw_write.count_we && fast_wrap) |=> count_value == 8'h00)
        else $error("fast wrap wrong");
    fast_ovf_a: assert property (@(posedge core_clk) disable iff (srst)
        (timer_tick && !sw_write.count_we && waveform_mode_select == timer8_pkg::MODE_FAST
        && count_value == 8'hfe) |=> overflow_flag) else $error("fast ovf late");
    phase_ovf_a: assert property (@(posedge core_clk) disable iff (srst)
        (timer_tick && !sw_write.count_we && phase && !counting_up
        && count_value == 8'h01) |=> overflow_flag) else $error("dual ovf late");
    phase_hold_a: assert property (@(posedge core_clk) disable iff (srst)
        (timer_tick && !sw_write.count_we && at_max_turn) |=> count_value == 8'hfe
        && !counting_up) else $error("max held too long");
    match_flag_a: assert property (@(posedge core_clk) disable iff (srst)
        cmp_event |=> compare_match_flag) else $error("match flag not set");
    write_block_a: assert property (@(posedge core_clk) disable iff (srst)
        sw_write.count_we |=> !match) else $error("match not blocked");
    no_tick_a: assert property (@(posedge core_clk) disable iff (srst)
        (!timer_tick && !sw_write.count_we) |=> $stable(count_value))
        else $error("count moved without tick");
    pin_gate_a: assert property (@(posedge core_clk) disable iff (srst)
        !output_pin_direction |-> !pin_oe) else $error("pin driven as input");
    cov_ctc: cover property (@(posedge core_clk) cmp_event
        && waveform_mode_select == timer8_pkg::MODE_CTC);
    cov_fast: cover property (@(posedge core_clk) fast_wrap && timer_tick);
    cov_phase: cover property (@(posedge core_clk) at_max_turn && timer_tick);
endmodule

// ### dv/pin_pad_model.sv
// partner model: port pad with pull-up, fed by the timer pin logic
`timescale 1ns/1ns
module pin_pad_model
(
    input wire logic pin_out, // level offered by the timer pin logic
    input wire logic pin_oe, // high while the timer side drives the pad
    output logic pad_level // level seen on the board
);
    // released pad floats up to the pull-up, never to a stale value
    assign pad_level = pin_oe ? pin_out : 1'b1;
endmodule

// ### dv/tb.sv
// testbench: hand-written scenarios for the 8-bit waveform timer
`timescale 1ns/1ns
module tb;
    logic core_clk = 1'b0; // 10 MHz system clock
    logic srst = 1'b1; // synchronous reset, held at start
    logic timer_tick = 1'b0; // prescaled enable
    logic [1:0] mode = 2'h0; // waveform mode drive
    logic [1:0] action = 2'h0; // output action drive
    timer8_pkg::sw_write_t sw_write = '0; // software strobes
    logic output_pin_direction = 1'b1; // pin direction drive
    logic port_data = 1'b1; // general port level
    logic [7:0] count_value; // observed count
    logic [7:0] compare_value; // observed active compare
    logic overflow_flag; // observed overflow flag
    logic compare_match_flag; // observed match flag
    logic pin_out; // observed pin level
    logic pin_oe; // observed pin enable
    logic pad_level; // pad level from the partner
    int n_mismatch = 0; // mismatches seen
    int total_checks = 0; // comparisons made

    // clock: half period of 50 ns
    always #50 core_clk = ~core_clk;

    timer8_waveform_modes u_dut
    (
        .core_clk(core_clk),
        .srst(srst),
        .timer_tick(timer_tick),
        .waveform_mode_select(mode),
        .compare_output_action(action),
        .sw_write(sw_write),
        .output_pin_direction(output_pin_direction),
        .port_data(port_data),
        .count_value(count_value),
        .compare_value(compare_value),
        .compare_buffer(),
        .overflow_flag(overflow_flag),
        .compare_match_flag(compare_match_flag),
        .pin_out(pin_out),
        .pin_oe(pin_oe)
    );

    pin_pad_model u_pad
    (
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .pad_level(pad_level)
    );

    // compare of byte-wide results
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // compare of single-bit results
    task automatic chk1(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask

    // closing report, the single exit of the run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one-cycle software strobe; taken at the edge that lowers it
    task automatic pulse(input timer8_pkg::sw_write_t w);
        @(posedge core_clk);
        sw_write <= w;
        @(posedge core_clk);
        sw_write <= '0;
        #1;
    endtask

    task automatic wr_count(input logic [7:0] v);
        pulse('{count_we: 1'b1, count_wdata: v, default: '0});
    endtask

    task automatic wr_cmp(input logic [7:0] v);
        pulse('{compare_we: 1'b1, compare_wdata: v, default: '0});
    endtask

    // both flags cleared by write-one
    task automatic clr_flags();
        pulse('{ovf_clear: 1'b1, cmp_clear: 1'b1, default: '0});
    endtask

    task automatic set_mode(input logic [1:0] m, input logic [1:0] a);
        @(posedge core_clk);
        mode <= m;
        action <= a;
    endtask

    // n consecutive ticks, then one idle edge so flags land
    task automatic run_ticks(input int n);
        @(posedge core_clk);
        timer_tick <= 1'b1;
        repeat (n) @(posedge core_clk);
        timer_tick <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    // free-running wrap, idle hold, and a match with no action
    task automatic test_normal();
        set_mode(timer8_pkg::MODE_NORMAL, timer8_pkg::ACT_NONE);
        wr_count(8'hff);
        repeat (3) @(posedge core_clk);
        #1;
        chk8("idle count", 8'hff, count_value);
        run_ticks(2);
        chk8("wrap count", 8'h01, count_value);
        chk1("normal ovf", 1'b1, overflow_flag);
        chk1("normal match flag", 1'b1, compare_match_flag);
        chk1("port passthrough", 1'b1, pin_out);
        clr_flags();
        chk1("flag clear", 1'b0, compare_match_flag);
        $display("test normal done");
    endtask

    // clear on compare, toggle, blocking, low write, half rate
    task automatic test_ctc();
        set_mode(timer8_pkg::MODE_CTC, timer8_pkg::ACT_TOGGLE);
        wr_cmp(8'h03);
        wr_count(8'h00);
        run_ticks(5);
        chk8("ctc count", 8'h01, count_value);
        chk1("ctc toggle", 1'b1, pin_out);
        chk1("ctc match flag", 1'b1, compare_match_flag);
        clr_flags();
        wr_cmp(8'h05);
        wr_count(8'h05);
        run_ticks(1);
        chk8("blocked count", 8'h06, count_value);
        chk1("blocked flag", 1'b0, compare_match_flag);
        wr_cmp(8'h00);
        run_ticks(1);
        chk8("low compare", 8'h07, count_value);
        wr_count(8'hff);
        run_ticks(1);
        chk1("ctc ovf", 1'b1, overflow_flag);
        for (int i = 0; i < 3; i++)
        begin
            run_ticks(1);
            chk1("half rate", i[0], pin_out);
        end
        $display("test ctc done");
    endtask

    // single slope: buffered compare, set at bottom, clear at match
    task automatic test_fast();
        set_mode(timer8_pkg::MODE_FAST, timer8_pkg::ACT_CLEAR);
        wr_cmp(8'h10);
        chk8("fast buffered", 8'h00, compare_value);
        clr_flags();
        wr_count(8'hfe);
        run_ticks(1);
        chk1("fast ovf", 1'b1, overflow_flag);
        run_ticks(1);
        chk8("fast bottom", 8'h00, count_value);
        chk8("fast loaded", 8'h10, compare_value);
        chk1("fast set", 1'b1, pin_out);
        run_ticks(17);
        chk1("fast clear", 1'b0, pin_out);
        output_pin_direction <= 1'b0;
        #1;
        chk1("pin released", 1'b0, pin_oe);
        chk1("pad pulled", 1'b1, pad_level);
        output_pin_direction <= 1'b1;
        $display("test fast done");
    endtask

    // dual slope from above compare, inverting action
    task automatic test_phase();
        set_mode(timer8_pkg::MODE_PHASE, timer8_pkg::ACT_SET);
        wr_cmp(8'h80);
        clr_flags();
        wr_count(8'hfd);
        run_ticks(2);
        chk8("phase top", 8'hff, count_value);
        run_ticks(1);
        chk8("phase turn", 8'hfe, count_value);
        chk1("missed up", 1'b1, pin_out);
        chk8("phase loaded", 8'h80, compare_value);
        run_ticks(127);
        chk1("down match", 1'b0, pin_out);
        run_ticks(127);
        chk8("phase bottom", 8'h00, count_value);
        chk1("phase ovf", 1'b1, overflow_flag);
        $display("test phase done");
    endtask

    // bound on the whole run
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        report_and_stop();
    end

    // main sequence
    initial
    begin
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        test_normal();
        test_ctc();
        test_fast();
        test_phase();
        report_and_stop();
    end
endmodule
